// ===== dac_mode_control.sv
// Purpose: Mode control bank of a stereo converter behind an Avalon-MM slave.
// Assumes: 20 MHz sys_clk; samples arrive already framed on the same clock.
// Notes: Software writes 16-bit control words or single data bytes per index.
//        Every access answers after exactly one wait state.
`timescale 1ns/1ps
`default_nettype none
`include "dac_mode_cfg.svh"

module dac_mode_control #(
  parameter int SAMPLE_W = 24
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [SAMPLE_W-1:0] leftSample,
  input wire logic [SAMPLE_W-1:0] rightSample,
  input wire logic sampleValid,
  output logic [SAMPLE_W-1:0] analogOutLeft,
  output logic [SAMPLE_W-1:0] analogOutRight,
  output logic zeroFlagRight,
  output logic zeroFlagLeft,
  output dac_mode_pkg::filter_cfg_s filterCfg,
  output logic [4:0] rightJustWordLength
);

  // ========================================================================
  // State
  // ========================================================================
  // All registered state of the bank outside the two channel stages sits in one struct.
  // The mode bytes hold only writable bits, so reserved bits read 0.
  // The ack bit is high for the one cycle in which a request is answered.
  // Read data is held here so it stands for the whole answer cycle.
  // Flag pins are registered so they never glitch while the polarity or
  // combine setting changes under them.
  typedef struct packed {
    dac_mode_pkg::ctrl_bank_s bank;
    logic ack;
    logic [31:0] readData;
    logic rejected;
    logic flagPin11;
    logic flagPin12;
  } bank_state_s;

  // Current and next copies of the whole state.
  bank_state_s state_reg;
  bank_state_s state_next;

  // Decode helpers and the zero detect of each channel stage.
  logic zeroLeft;
  logic zeroRight;
  logic [5:0] regIndex;
  logic aligned;
  logic accepted;

  // ========================================================================
  // Channel stages
  // ========================================================================
  // One stage per channel keeps both sides identical. Both share the
  // phase bit, since one setting inverts the whole stereo output.
  channel_output_stage #(
    .SAMPLE_W(SAMPLE_W)
  ) leftStage (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .sampleIn(leftSample),
    .sampleValid(sampleValid),
    .outputDisable(state_reg.bank.outputCtl[`BIT_LEFT_DISABLE]),
    .phaseInvert(state_reg.bank.zflagCtl[`BIT_PHASE_INVERT]),
    .levelOut(analogOutLeft),
    .zeroDetect(zeroLeft)
  );

  // The right stage mirrors the left one.
  channel_output_stage #(
    .SAMPLE_W(SAMPLE_W)
  ) rightStage (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .sampleIn(rightSample),
    .sampleValid(sampleValid),
    .outputDisable(state_reg.bank.outputCtl[`BIT_RIGHT_DISABLE]),
    .phaseInvert(state_reg.bank.zflagCtl[`BIT_PHASE_INVERT]),
    .levelOut(analogOutRight),
    .zeroDetect(zeroRight)
  );

  // ========================================================================
  // Bus decode
  // ========================================================================
  // Every access waits exactly one cycle, so read data is always registered.
  // That halves the peak bus rate but keeps the read mux out of any
  // path from the address pins to the read data pins.
  // Address bits below the word carry no index and must be zero.
  // Waitrequest rises with the request and falls once ack is set.
  assign regIndex = avs_address[7:2];
  assign aligned = (avs_address[1:0] == 2'b00);
  assign accepted = (avs_read || avs_write) && state_reg.ack;
  assign avs_waitrequest = (avs_read || avs_write) && !state_reg.ack;

  // Applies one data byte to the addressed index; unknown indices are ignored.
  // Both write ports share this decode, so a soft reset sent in a control
  // word acts exactly like one sent as a byte.
  // Masking keeps reserved bits at zero even if a writer sets them.
  // Unmapped indices fall through to the default and change nothing.
  function automatic dac_mode_pkg::ctrl_bank_s applyByte(
    input dac_mode_pkg::ctrl_bank_s cur,
    input logic [5:0] idx,
    input logic [7:0] data
  );
    dac_mode_pkg::ctrl_bank_s res;
    res = cur;
    unique case (idx)
      `IDX_SOFT_RESET: begin
        if (data[`BIT_SOFT_RESET]) begin
          res.outputCtl = `RST_OUTPUT_CTL;
          res.formatCtl = `RST_FORMAT_CTL;
          res.zflagCtl = `RST_ZFLAG_CTL;
        end
      end
      `IDX_OUTPUT_CTL: res.outputCtl = data & `MASK_OUTPUT_CTL;
      `IDX_FORMAT_CTL: res.formatCtl = data & `MASK_FORMAT_CTL;
      `IDX_ZFLAG_CTL: res.zflagCtl = data & `MASK_ZFLAG_CTL;
      default: res = cur;
    endcase
    return res;
  endfunction

  // Read view of an index: stored bytes, status, or zero when unmapped.
  // The soft reset index reads zero, since its bit clears itself at once.
  function automatic logic [31:0] readView(
    input bank_state_s cur,
    input logic [5:0] idx,
    input logic zl,
    input logic zr
  );
    logic [31:0] res;
    res = 32'h0000_0000;
    unique case (idx)
      `IDX_OUTPUT_CTL: res[7:0] = cur.bank.outputCtl;
      `IDX_FORMAT_CTL: res[7:0] = cur.bank.formatCtl;
      `IDX_ZFLAG_CTL: res[7:0] = cur.bank.zflagCtl;
      `IDX_STATUS: begin
        res[`BIT_STAT_ZERO_LEFT] = zl;
        res[`BIT_STAT_ZERO_RIGHT] = zr;
        res[`BIT_STAT_REJECTED] = cur.rejected;
      end
      default: res = 32'h0000_0000;
    endcase
    return res;
  endfunction

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb begin
    logic wordOk;
    logic [15:0] word;
    logic setRejected;
    logic clrRejected;
    logic [5:0] wordIdx;
    wordOk = 1'b0;
    wordIdx = 6'h3f;
    word = avs_writedata[15:0];
    setRejected = 1'b0;
    clrRejected = 1'b0;
    // Every field keeps its value unless a branch below replaces it.
    state_next = state_reg;

    // Ack pulses for one cycle after each request cycle that waited.
    // A request left up past its answer would start a second access.
    state_next.ack = (avs_read || avs_write) && !state_reg.ack;

    // Read data is captured in the wait cycle and stands during the answer.
    // Unaligned reads answer zero.
    if (avs_read && !state_reg.ack) begin
      state_next.readData = aligned ? readView(state_reg, regIndex, zeroLeft, zeroRight)
                                    : 32'h0000_0000;
    end

    // Writes take effect only on the edge where waitrequest is low.
    // A control word needs both low lanes, as index and data travel together.
    // A byte write uses lane 0 only; the other lanes carry nothing here.
    if (avs_write && accepted && aligned) begin
      if (regIndex == `IDX_CTRL_WORD) begin
        if (avs_byteenable[1:0] == 2'b11) begin
          wordOk = (word[`WORD_ZERO_BIT] == 1'b0);
          setRejected = !wordOk;
          // Indices beyond six bits land on an unmapped slot and are dropped.
          if (word[`WORD_INDEX_HI] == 1'b0) begin
            wordIdx = word[`WORD_INDEX_HI - 1:`WORD_INDEX_LO];
          end
          if (wordOk) begin
            state_next.bank = applyByte(state_reg.bank, wordIdx, word[7:0]);
          end
        end
      end else if (regIndex == `IDX_STATUS) begin
        // Writing one to the rejected bit clears it; the rest is read-only.
        clrRejected = avs_byteenable[0] && avs_writedata[`BIT_STAT_REJECTED];
      end else if (avs_byteenable[0]) begin
        state_next.bank = applyByte(state_reg.bank, regIndex, avs_writedata[7:0]);
      end
    end

    // A rejected word arriving with a clear still leaves the flag set.
    // The flag stays set until software clears it, so no refusal is missed.
    if (setRejected) begin
      state_next.rejected = 1'b1;
    end else if (clrRejected) begin
      state_next.rejected = 1'b0;
    end

    // Zero flag pins follow polarity and combine settings of the live bank.
    // In combined mode the spare pin is held low whatever the polarity, so
    // a board that leaves it open sees no toggling.
    // The pins lag the stage outputs by one cycle.
    if (state_reg.bank.zflagCtl[`BIT_ZFLAG_COMBINE]) begin
      state_next.flagPin11 = (zeroLeft && zeroRight)
                             ^ state_reg.bank.zflagCtl[`BIT_ZFLAG_POLARITY];
      state_next.flagPin12 = 1'b0;
    end else begin
      state_next.flagPin11 = zeroRight
                             ^ state_reg.bank.zflagCtl[`BIT_ZFLAG_POLARITY];
      state_next.flagPin12 = zeroLeft
                             ^ state_reg.bank.zflagCtl[`BIT_ZFLAG_POLARITY];
    end
  end

  // ========================================================================
  // State register
  // ========================================================================
  // Reset loads the default settings; the soft reset path loads the same.
  // Only power-on reset is asynchronous; the soft reset acts through the
  // next state logic, which keeps data out of the reset tree.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg.bank.outputCtl <= `RST_OUTPUT_CTL;
      state_reg.bank.formatCtl <= `RST_FORMAT_CTL;
      state_reg.bank.zflagCtl <= `RST_ZFLAG_CTL;
      state_reg.ack <= 1'b0;
      state_reg.readData <= 32'h0000_0000;
      state_reg.rejected <= 1'b0;
      state_reg.flagPin11 <= 1'b0;
      state_reg.flagPin12 <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  // Read data and flag pins come straight from flip-flops; of the bus outputs only waitrequest
  // is combinational, as the handshake needs it in the request cycle.
  assign avs_readdata = state_reg.readData;
  assign zeroFlagRight = state_reg.flagPin11;
  assign zeroFlagLeft = state_reg.flagPin12;

  // Filter path settings decode straight from the stored bytes.
  // Reserved rate and format codes pass out unchanged; the filter path
  // decides what to do with them.
  always_comb begin
    filterCfg.deemphEnable = state_reg.bank.outputCtl[`BIT_DEEMPH_ENABLE];
    filterCfg.deemphRate = dac_mode_pkg::deemph_rate_e'(
      state_reg.bank.outputCtl[`BIT_DEEMPH_RATE_LO +: 2]);
    filterCfg.audioFormat = dac_mode_pkg::audio_format_e'(
      state_reg.bank.formatCtl[`BIT_FORMAT_LO +: 3]);
    filterCfg.rolloffSlow = state_reg.bank.formatCtl[`BIT_ROLLOFF];
  end

  // Word length of right-justified codes; zero marks a framed format.
  // Framed formats take their length from the frame, not from here.
  // Reserved codes also report zero.
  always_comb begin
    unique case (filterCfg.audioFormat)
      dac_mode_pkg::FMT_RJ24: rightJustWordLength = 5'h18;
      dac_mode_pkg::FMT_RJ20: rightJustWordLength = 5'h14;
      dac_mode_pkg::FMT_RJ18: rightJustWordLength = 5'h12;
      dac_mode_pkg::FMT_RJ16: rightJustWordLength = 5'h10;
      default: rightJustWordLength = 5'h00;
    endcase
  end

endmodule

`default_nettype wire

// ===== dac_mode_cfg.svh
// Purpose: Offsets, field positions and reset values of the mode control bank.
// Assumes: Byte address of a bank register is four times its register index.
// Notes: Definitions only; included by bare name.
`ifndef DAC_MODE_CFG_SVH
`define DAC_MODE_CFG_SVH

// ==========================================================================
// Register indices and software offsets
// ==========================================================================
`define IDX_SOFT_RESET 6'h12
`define IDX_OUTPUT_CTL 6'h13
`define IDX_FORMAT_CTL 6'h14
`define IDX_ZFLAG_CTL 6'h16
`define IDX_CTRL_WORD 6'h00
`define IDX_STATUS 6'h01

// ==========================================================================
// Control word layout
// ==========================================================================
`define WORD_ZERO_BIT 15
`define WORD_INDEX_LO 8
`define WORD_INDEX_HI 14

// ==========================================================================
// Field positions inside the data byte
// ==========================================================================
`define BIT_SOFT_RESET 7
`define BIT_LEFT_DISABLE 0
`define BIT_RIGHT_DISABLE 1
`define BIT_DEEMPH_ENABLE 4
`define BIT_DEEMPH_RATE_LO 5
`define BIT_FORMAT_LO 0
`define BIT_ROLLOFF 5
`define BIT_PHASE_INVERT 0
`define BIT_ZFLAG_POLARITY 1
`define BIT_ZFLAG_COMBINE 2
`define BIT_STAT_ZERO_LEFT 0
`define BIT_STAT_ZERO_RIGHT 1
`define BIT_STAT_REJECTED 2

// ==========================================================================
// Reset values and writable-bit masks
// ==========================================================================
`define RST_OUTPUT_CTL 8'h00
`define RST_FORMAT_CTL 8'h05
`define RST_ZFLAG_CTL 8'h00
`define MASK_OUTPUT_CTL 8'h73
`define MASK_FORMAT_CTL 8'h27
`define MASK_ZFLAG_CTL 8'h07

`endif

// ===== dac_mode_pkg.sv
// Purpose: Types shared by the mode control bank, its assertions and its bench.
// Assumes: Constants live in dac_mode_cfg.svh.
// Notes: Nothing here holds a number other than field widths and enum codes.
`default_nettype none
package dac_mode_pkg;

  // Serial audio format codes.
  typedef enum logic [2:0] {
    FMT_RJ24 = 3'b000,
    FMT_RJ20 = 3'b001,
    FMT_RJ18 = 3'b010,
    FMT_RJ16 = 3'b011,
    FMT_TWO_CH_BUS = 3'b100,
    FMT_LEFT_JUST = 3'b101,
    FMT_RSV6 = 3'b110,
    FMT_RSV7 = 3'b111
  } audio_format_e;

  // De-emphasis sampling frequency codes.
  typedef enum logic [1:0] {
    RATE_44K1 = 2'b00,
    RATE_48K = 2'b01,
    RATE_32K = 2'b10,
    RATE_RSV = 2'b11
  } deemph_rate_e;

  // Stored data bytes of the three mode registers.
  typedef struct packed {
    logic [7:0] outputCtl;
    logic [7:0] formatCtl;
    logic [7:0] zflagCtl;
  } ctrl_bank_s;

  // Settings that leave the bank for the filter path.
  typedef struct packed {
    logic deemphEnable;
    deemph_rate_e deemphRate;
    audio_format_e audioFormat;
    logic rolloffSlow;
  } filter_cfg_s;

endpackage

`default_nettype wire

// ===== channel_output_stage.sv
// Purpose: One output channel: disable to bipolar zero, phase invert, zero detect.
// Assumes: Samples are two's complement, centred on zero, on the system clock.
// Notes: Both channels use this module; the bank instantiates it twice.
`timescale 1ns/1ps
`default_nettype none

module channel_output_stage #(
  parameter int SAMPLE_W = 24
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [SAMPLE_W-1:0] sampleIn,
  input wire logic sampleValid,
  input wire logic outputDisable,
  input wire logic phaseInvert,
  output logic [SAMPLE_W-1:0] levelOut,
  output logic zeroDetect
);

  typedef struct packed {
    logic [SAMPLE_W-1:0] level;
    logic zero;
  } stage_s;

  localparam logic [SAMPLE_W-1:0] MOST_NEG = {1'b1, {(SAMPLE_W-1){1'b0}}};
  localparam logic [SAMPLE_W-1:0] MOST_POS = {1'b0, {(SAMPLE_W-1){1'b1}}};

  stage_s state_reg;
  stage_s state_next;

  // Negating the most negative code would wrap, so it saturates instead.
  always_comb begin
    state_next = state_reg;
    if (sampleValid) begin
      state_next.zero = (sampleIn == '0);
      if (outputDisable) begin
        state_next.level = '0;
      end else if (phaseInvert) begin
        state_next.level = (sampleIn == MOST_NEG) ? MOST_POS : -sampleIn;
      end else begin
        state_next.level = sampleIn;
      end
    end else if (outputDisable) begin
      state_next.level = '0;
    end
  end

  // State register; a disabled channel rests at bipolar zero from reset.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign levelOut = state_reg.level;
  assign zeroDetect = state_reg.zero;

endmodule

`default_nettype wire

// ===== dac_host_model.sv
// Purpose: Host controller that writes mode words to the bank over Avalon-MM.
// Assumes: The slave answers by dropping waitrequest; no cycle count is assumed.
// Notes: The bench calls the tasks hierarchically; the bench timeout ends a hang.
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
  input wire logic sys_clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  // ==========================================================================
  // Bus cycles
  // Idle bus from time zero so the slave never sees an unknown request.
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end

  // Holds the request until waitrequest is seen low at an edge, then releases it.
  task automatic access(input logic rdn, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= rdn;
    avs_write <= !rdn;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Packs a control word; top is only set when a refusal is wanted.
  task automatic ctrlWord(input logic [6:0] idx, input logic [7:0] data, input logic top);
    logic [31:0] q;
    access(1'b0, 8'h00, {16'h0000, top, idx, data}, 4'h3, q);
  endtask
endmodule
`default_nettype wire

// ===== dac_mode_control_assertions.sv
// Purpose: Port-level checks of the mode control bank.
// Assumes: Channel bytes are shadowed from completed bus writes.
// Notes: Bound to dac_mode_control after the module.
`timescale 1ns/1ps
`default_nettype none
module dac_mode_control_assertions #(
  parameter int SAMPLE_W = 24
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic [SAMPLE_W-1:0] leftSample,
  input wire logic [SAMPLE_W-1:0] rightSample,
  input wire logic sampleValid,
  input wire logic [SAMPLE_W-1:0] analogOutLeft,
  input wire logic [SAMPLE_W-1:0] analogOutRight,
  input wire logic zeroFlagRight,
  input wire logic zeroFlagLeft,
  input wire dac_mode_pkg::filter_cfg_s filterCfg,
  input wire logic [4:0] rightJustWordLength
);
  // ==========================================================================
  // Shadow of the bytes that steer the channels
  logic wOk;
  logic [6:0] wIdx;
  logic [7:0] outC;
  logic [7:0] zC;
  // Word port carries its own index; byte ports take it from the address.
  assign wIdx = (avs_address == 8'h00) ? avs_writedata[14:8] : {1'b0, avs_address[7:2]};
  assign wOk = avs_write && !avs_waitrequest && ((avs_address == 8'h00) ?
    (avs_byteenable[1:0] == 2'h3 && !avs_writedata[15]) :
    (avs_address[1:0] == 2'h0 && avs_byteenable[0]));

  // Soft reset wins over a same-cycle field update, as in the bank.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      outC <= 8'h00;
      zC <= 8'h00;
    end else if (wOk && wIdx == 7'h12 && avs_writedata[7]) begin
      outC <= 8'h00;
      zC <= 8'h00;
    end else if (wOk) begin
      outC <= (wIdx == 7'h13) ? avs_writedata[7:0] : outC;
      zC <= (wIdx == 7'h16) ? avs_writedata[7:0] : zC;
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence sSepFlags;
    sampleValid ##1 !zC[2];
  endsequence
  sequence sComFlags;
    sampleValid ##1 zC[2];
  endsequence

  a_soft_reset: assert property (wOk && wIdx == 7'h12 && avs_writedata[7] |=> filterCfg == 7'h0a)
    else $error("soft reset left filter settings");
  a_left_pass: assert property (sampleValid && !outC[0] && !zC[0] |=> analogOutLeft == $past(leftSample))
    else $error("left output lost the sample");
  a_left_zero: assert property (outC[0] |=> analogOutLeft == '0)
    else $error("disabled left output not at zero");
  a_right_zero: assert property (outC[1] |=> analogOutRight == '0)
    else $error("disabled right output not at zero");
  a_phase_inv: assert property (sampleValid && !outC[1] && zC[0] && rightSample[SAMPLE_W-2:0] != '0
    |=> analogOutRight == -$past(rightSample)) else $error("right output not inverted");
  a_flag_sep: assert property (sSepFlags |=> zeroFlagLeft == (($past(leftSample, 2) == '0) ^ $past(zC[1]))
    && zeroFlagRight == (($past(rightSample, 2) == '0) ^ $past(zC[1]))) else $error("separate flags wrong");
  a_flag_common: assert property (sComFlags |=> !zeroFlagLeft && zeroFlagRight ==
    (($past(leftSample, 2) == '0 && $past(rightSample, 2) == '0) ^ $past(zC[1]))) else $error("common flag wrong");
  a_rj_length: assert property (rightJustWordLength == (filterCfg.audioFormat == 3'b000 ? 5'd24 :
    filterCfg.audioFormat == 3'b001 ? 5'd20 : filterCfg.audioFormat == 3'b010 ? 5'd18 :
    filterCfg.audioFormat == 3'b011 ? 5'd16 : 5'd0)) else $error("word length does not match format");
  a_cfg_reset: assert property ($rose(arst_n) |-> filterCfg == 7'h0a)
    else $error("filter settings not at default after reset");
  a_cfg_hold: assert property (!(avs_write && !avs_waitrequest) |=> $stable(filterCfg))
    else $error("filter settings changed without a write");
endmodule
bind dac_mode_control dac_mode_control_assertions #(.SAMPLE_W(SAMPLE_W)) chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .leftSample(leftSample), .rightSample(rightSample),
  .sampleValid(sampleValid), .analogOutLeft(analogOutLeft), .analogOutRight(analogOutRight),
  .zeroFlagRight(zeroFlagRight), .zeroFlagLeft(zeroFlagLeft), .filterCfg(filterCfg),
  .rightJustWordLength(rightJustWordLength));
`default_nettype wire

// ===== test_audio_dac_mode_control_fields.sv
// Purpose: Self-checking bench of the mode control bank.
// Assumes: Host model drives the bus; the bench drives samples.
// Notes: Settings are read at the falling edge, after the bank has updated.
`timescale 1ns/1ps
`default_nettype none
module test_audio_dac_mode_control_fields;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic avs_read, avs_write, avs_waitrequest, sampleValid, zeroFlagRight, zeroFlagLeft;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [23:0] leftSample, rightSample, analogOutLeft, analogOutRight;
  logic [4:0] rightJustWordLength;
  logic [4:0] rjLen [4] = '{5'd24, 5'd20, 5'd18, 5'd16};
  dac_mode_pkg::filter_cfg_s filterCfg;
  int errTotal = 0;
  int samplesChecked = 0;

  // ==========================================================================
  // Clock and instances
  always #25 sys_clk = ~sys_clk;
  dac_host_model dac_host_model_inst (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
  dac_mode_control #(.SAMPLE_W(24)) dac_mode_control_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .leftSample(leftSample), .rightSample(rightSample),
    .sampleValid(sampleValid), .analogOutLeft(analogOutLeft), .analogOutRight(analogOutRight),
    .zeroFlagRight(zeroFlagRight), .zeroFlagLeft(zeroFlagLeft), .filterCfg(filterCfg),
    .rightJustWordLength(rightJustWordLength));

  // ==========================================================================
  // Tasks
  // Counts every comparison and reports each mismatch.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Byte write; waits half a cycle so the new settings have landed.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    dac_host_model_inst.access(1'b0, a, {24'h0, d}, 4'h1, rd);
    @(negedge sys_clk);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    dac_host_model_inst.access(1'b1, a, 32'h0, 4'hf, rd);
    check(rd, {24'h0, exp});
  endtask
  // One sample; returns once the output and the flag pins have both moved.
  task automatic send(input logic [23:0] l, input logic [23:0] r);
    @(posedge sys_clk);
    leftSample <= l;
    rightSample <= r;
    sampleValid <= 1'b1;
    @(posedge sys_clk);
    sampleValid <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  // A hang costs far more than the fewer than two hundred cycles the tests need.
  initial begin
    repeat (5000) @(posedge sys_clk);
    errTotal++;
    summarize();
  end

  initial begin
    sampleValid = 1'b0;
    leftSample = 24'h0;
    rightSample = 24'h0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    rdChk(8'h4c, 8'h00);
    rdChk(8'h50, 8'h05);
    rdChk(8'h58, 8'h00);
    check(32'(filterCfg), 32'h0a);
    $display("test defaults done");
    for (int c = 0; c < 8; c++) begin
      wr(8'h50, {2'h0, c[0], 2'h0, c[2:0]});
      check(32'(filterCfg.audioFormat), c);
      check(32'(filterCfg.rolloffSlow), c[0]);
      check(32'(rightJustWordLength), c < 4 ? rjLen[c[1:0]] : 5'd0);
    end
    $display("test formats done");
    for (int r = 0; r < 4; r++) begin
      dac_host_model_inst.ctrlWord(7'h13, {1'b0, r[1:0], 5'h10}, 1'b0);
      @(negedge sys_clk);
      check(32'({filterCfg.deemphEnable, filterCfg.deemphRate}), 4 + r);
    end
    dac_host_model_inst.ctrlWord(7'h13, 8'h00, 1'b1);
    rdChk(8'h04, 8'h04);
    rdChk(8'h4c, 8'h70);
    $display("test control words done");
    for (int d = 0; d < 4; d++) begin
      wr(8'h4c, 8'(d));
      send(24'h123456, 24'h654321);
      check(analogOutLeft, d[0] ? 24'h0 : 24'h123456);
      check(analogOutRight, d[1] ? 24'h0 : 24'h654321);
    end
    $display("test channels done");
    wr(8'h4c, 8'h00);
    for (int z = 0; z < 8; z++) begin
      wr(8'h58, 8'(z));
      send(24'h000000, 24'h000010);
      check(analogOutRight, z[0] ? 24'hfffff0 : 24'h000010);
      check({zeroFlagLeft, zeroFlagRight}, z[2] ? {1'b0, z[1]} : {!z[1], z[1]});
    end
    wr(8'h58, 8'h04);
    send(24'h000000, 24'h000000);
    check({zeroFlagLeft, zeroFlagRight}, 2'b01);
    // Both channels saw zero, and the refused word is still flagged until cleared.
    rdChk(8'h04, 8'h07);
    wr(8'h04, 8'h04);
    rdChk(8'h04, 8'h03);
    $display("test flags done");
    wr(8'h4c, 8'h73);
    wr(8'h50, 8'h20);
    wr(8'h48, 8'h80);
    check(32'(filterCfg), 32'h0a);
    rdChk(8'h4c, 8'h00);
    rdChk(8'h50, 8'h05);
    rdChk(8'h58, 8'h00);
    $display("test soft reset done");
    summarize();
  end
endmodule
`default_nettype wire
